// File: hdl/scw_status_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "scw_regs.svh"
module scw_status_control
    import scw_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    // indirect register ports, host side, same clock
    input wire logic index_port_wr,
    input wire logic [15:0] index_port_wdata,
    input wire logic value_port_wr,
    input wire logic value_port_rd,
    input wire logic [15:0] value_port_wdata,
    output logic [15:0] index_port_rdata,
    output logic [15:0] value_port_rdata,
    // event pulses from internal units, same clock
    input wire logic bus_timeout_ev,
    input wire logic rx_done_ev,
    input wire logic tx_done_ev,
    input wire logic setup_read_done,
    input wire logic overlong_ev,
    input wire logic colltest_ev,
    input wire logic dropped_ev,
    input wire logic descr_fetch_done,
    // level status from other units
    input wire logic missed_count_overflow,
    input wire logic collision_count_overflow,
    input wire logic long_talk_flag,
    input wire logic tx_begin_flag,
    // mask and configuration bits held elsewhere
    input wire logic overlong_mask,
    input wire logic dropped_mask,
    input wire logic bus_timeout_mask,
    input wire logic rx_done_mask,
    input wire logic tx_done_mask,
    input wire logic setup_done_mask,
    input wire logic receiver_disable_cfg,
    input wire logic transmitter_disable_cfg,
    input wire logic auto_poll_disable,
    // controls to the rest of the controller
    output logic irq,
    output logic stopped,
    output logic setup_start,
    output logic tx_poll_go,
    output logic receiver_active,
    output logic transmitter_active
);
    logic [`SCW_IDX_W-1:0] index_reg;
    logic sel;
    logic wr_w;
    logic [15:0] wd;
    logic stop_reg;
    logic go_reg;
    logic setup_reg;
    logic irq_gate_reg;
    logic poll_now_reg;
    logic rx_act_reg;
    logic tx_act_reg;
    logic stop_clr;
    logic go_wr;
    logic setup_wr;
    logic stop_wr;
    logic bus_grant_timeout_flag;
    logic rx_done_flag;
    logic tx_done_flag;
    logic setup_done_flag;
    logic overlong_transmit_flag;
    logic collision_test_flag;
    logic dropped_flag;
    logic err_sum;
    logic pending_summary;
    logic [15:0] word;
    scw_state_t state_reg;

    // decode of the value port onto the selected register
    assign sel = (index_reg == `SCW_IDX_STATUS_CONTROL);
    assign wr_w = value_port_wr && sel;
    assign wd = value_port_wdata;
    assign stop_wr = wr_w && wd[`SCW_B_STOP];
    assign go_wr = wr_w && wd[`SCW_B_GO] && !wd[`SCW_B_STOP];
    assign setup_wr = wr_w && wd[`SCW_B_SETUP] && !wd[`SCW_B_STOP];
    // stop written clears the flags in the same edge it takes effect
    assign stop_clr = stop_wr;

    // index port, cleared by reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            index_reg <= '0;
        end else if (index_port_wr) begin
            index_reg <= index_port_wdata[`SCW_IDX_W-1:0];
        end
    end

    // configuration levels may come from a slower register domain, so two
    // flops come first; the enables are read in every run cycle, so the lag delays the active bits, and a stale enable can set one that then holds until stop
    logic [2:0] cfg_sync;
    scw_sync #(
        .W(3)
    ) u_cfg_sync (
        .clk(clk),
        .rstn(rstn),
        .d({auto_poll_disable, transmitter_disable_cfg, receiver_disable_cfg}),
        .q(cfg_sync)
    );

    // event flags share one sticky cell shape
    scw_flag u_bus_timeout (
        .clk(clk), .rstn(rstn), .set_ev(bus_timeout_ev && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_BUSTMO]), .stop_clr(stop_clr),
        .flag(bus_grant_timeout_flag));
    scw_flag u_rx_done (
        .clk(clk), .rstn(rstn), .set_ev(rx_done_ev && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_RXDONE]), .stop_clr(stop_clr),
        .flag(rx_done_flag));
    scw_flag u_tx_done (
        .clk(clk), .rstn(rstn), .set_ev(tx_done_ev && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_TXDONE]), .stop_clr(stop_clr),
        .flag(tx_done_flag));
    scw_flag u_setup_done (
        .clk(clk), .rstn(rstn),
        .set_ev(setup_read_done && state_reg == SCW_SETUP && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_SETUPDONE]), .stop_clr(stop_clr),
        .flag(setup_done_flag));
    scw_flag u_overlong (
        .clk(clk), .rstn(rstn), .set_ev(overlong_ev && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_OVERLONG]), .stop_clr(stop_clr),
        .flag(overlong_transmit_flag));
    scw_flag u_colltest (
        .clk(clk), .rstn(rstn), .set_ev(colltest_ev && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_COLLTEST]), .stop_clr(stop_clr),
        .flag(collision_test_flag));
    scw_flag u_dropped (
        .clk(clk), .rstn(rstn), .set_ev(dropped_ev && !stop_reg),
        .clr_w1(wr_w && wd[`SCW_B_DROPPED]), .stop_clr(stop_clr),
        .flag(dropped_flag));

    // error summary follows the four error flags
    assign err_sum = overlong_transmit_flag || collision_test_flag ||
                     dropped_flag || bus_grant_timeout_flag;

    // pending summary is combinational so it drops as soon as causes clear;
    // flags are already zero while stopped, level sources are gated here
    assign pending_summary = !stop_reg && (
        (overlong_transmit_flag && !overlong_mask) ||
        (dropped_flag && !dropped_mask) ||
        (bus_grant_timeout_flag && !bus_timeout_mask) ||
        missed_count_overflow || collision_count_overflow ||
        (rx_done_flag && !rx_done_mask) ||
        (tx_done_flag && !tx_done_mask) ||
        (setup_done_flag && !setup_done_mask) ||
        long_talk_flag || tx_begin_flag);

    // interrupt gate follows written value; a stop write clears it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_gate_reg <= 1'b0;
        end else if (stop_clr) begin
            irq_gate_reg <= 1'b0;
        end else if (wr_w) begin
            irq_gate_reg <= wd[`SCW_B_IRQGATE];
        end
    end

    // irq registered so the pin comes from a flop; one cycle behind pending
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= pending_summary && irq_gate_reg;
        end
    end

    // stop bit: set by write one or reset, cleared by go or setup
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_reg <= 1'b1;
        end else if (stop_wr) begin
            stop_reg <= 1'b1;
        end else if (go_wr || setup_wr) begin
            stop_reg <= 1'b0;
        end
    end

    // go and setup request bits, held until stop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            go_reg <= 1'b0;
            setup_reg <= 1'b0;
        end else if (stop_wr) begin
            go_reg <= 1'b0;
            setup_reg <= 1'b0;
        end else begin
            if (go_wr) begin
                go_reg <= 1'b1;
            end
            if (setup_wr) begin
                setup_reg <= 1'b1;
            end
        end
    end

    // sequencer: setup read first when both requested together
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SCW_IDLE;
        end else if (stop_wr) begin
            state_reg <= SCW_IDLE;
        end else begin
            unique case (state_reg)
                SCW_IDLE: begin
                    if (setup_wr) begin
                        state_reg <= SCW_SETUP;
                    end else if (go_wr) begin
                        state_reg <= SCW_RUN;
                    end
                end
                SCW_SETUP: begin
                    if (setup_read_done) begin
                        state_reg <= go_reg ? SCW_RUN : SCW_IDLE;
                    end
                end
                SCW_RUN: begin
                    state_reg <= SCW_RUN;
                end
            endcase
        end
    end

    // active bits rise in any run cycle while not disabled, and hold until stop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_act_reg <= 1'b0;
            tx_act_reg <= 1'b0;
        end else if (stop_wr) begin
            rx_act_reg <= 1'b0;
            tx_act_reg <= 1'b0;
        end else if (state_reg == SCW_RUN) begin
            rx_act_reg <= rx_act_reg || !cfg_sync[0];
            tx_act_reg <= tx_act_reg || !cfg_sync[1];
        end
    end

    // poll-now request; hazard: a fetch and a host write in one cycle,
    // the write wins so a fresh demand is never swallowed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            poll_now_reg <= 1'b0;
        end else if (stop_clr) begin
            poll_now_reg <= 1'b0;
        end else if (wr_w && wd[`SCW_B_POLLNOW]) begin
            poll_now_reg <= 1'b1;
        end else if (!tx_act_reg || descr_fetch_done) begin
            poll_now_reg <= 1'b0;
        end
    end

    // immediate descriptor fetch request to the engine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_poll_go <= 1'b0;
        end else begin
            tx_poll_go <= poll_now_reg && tx_act_reg && !stop_reg &&
                          !descr_fetch_done;
        end
    end

    // auto_poll_disable only changes who must issue the demand
    logic unused_cfg;
    assign unused_cfg = cfg_sync[2];

    // outputs to the rest of the controller
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stopped <= 1'b1;
            setup_start <= 1'b0;
            receiver_active <= 1'b0;
            transmitter_active <= 1'b0;
        end else begin
            stopped <= stop_reg || stop_wr;
            setup_start <= (state_reg == SCW_SETUP) && !stop_wr;
            receiver_active <= rx_act_reg && !stop_wr;
            transmitter_active <= tx_act_reg && !stop_wr;
        end
    end

    // assembled read word
    always_comb begin
        word = 16'h0000;
        word[`SCW_B_ERR] = err_sum;
        word[`SCW_B_OVERLONG] = overlong_transmit_flag;
        word[`SCW_B_COLLTEST] = collision_test_flag;
        word[`SCW_B_DROPPED] = dropped_flag;
        word[`SCW_B_BUSTMO] = bus_grant_timeout_flag;
        word[`SCW_B_RXDONE] = rx_done_flag;
        word[`SCW_B_TXDONE] = tx_done_flag;
        word[`SCW_B_SETUPDONE] = setup_done_flag;
        word[`SCW_B_PENDING] = pending_summary;
        word[`SCW_B_IRQGATE] = irq_gate_reg;
        word[`SCW_B_RXACT] = rx_act_reg;
        word[`SCW_B_TXACT] = tx_act_reg;
        word[`SCW_B_POLLNOW] = poll_now_reg;
        word[`SCW_B_STOP] = stop_reg;
        word[`SCW_B_GO] = go_reg;
        word[`SCW_B_SETUP] = setup_reg;
    end

    // read data registered; unselected index reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            value_port_rdata <= 16'h0000;
            index_port_rdata <= 16'h0000;
        end else begin
            index_port_rdata <= {9'h000, index_reg};
            if (value_port_rd) begin
                value_port_rdata <= sel ? word : 16'h0000;
            end
        end
    end
endmodule : scw_status_control
`default_nettype wire

// File: common/scw_regs.svh
`ifndef SCW_REGS_SVH
`define SCW_REGS_SVH
// register index of the status and control word behind the index port
`define SCW_IDX_STATUS_CONTROL 7'h00
`define SCW_IDX_W 7
// bit positions of the status and control word
`define SCW_B_ERR 15
`define SCW_B_OVERLONG 14
`define SCW_B_COLLTEST 13
`define SCW_B_DROPPED 12
`define SCW_B_BUSTMO 11
`define SCW_B_RXDONE 10
`define SCW_B_TXDONE 9
`define SCW_B_SETUPDONE 8
`define SCW_B_PENDING 7
`define SCW_B_IRQGATE 6
`define SCW_B_RXACT 5
`define SCW_B_TXACT 4
`define SCW_B_POLLNOW 3
`define SCW_B_STOP 2
`define SCW_B_GO 1
`define SCW_B_SETUP 0
// reset value: only stop set
`define SCW_RESET_VAL 16'h0004
`endif

// File: common/scw_pkg.sv
`default_nettype none
package scw_pkg;
    // sequencer states for start/setup handling
    typedef enum logic [1:0] {
        SCW_IDLE,
        SCW_SETUP,
        SCW_RUN
    } scw_state_t;
endpackage : scw_pkg
`default_nettype wire

// File: hdl/scw_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser, one per bit
module scw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    // first stage is read by the second stage only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : scw_sync
`default_nettype wire

// File: hdl/scw_flag.sv
`timescale 1ns/100ps
`default_nettype none
// sticky event flag, set by hardware, write-one-to-clear, cleared by stop
module scw_flag (
    input wire logic clk,
    input wire logic rstn,
    input wire logic set_ev,
    input wire logic clr_w1,
    input wire logic stop_clr,
    output logic flag
);
    // set beats host clear so a coincident event survives
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (stop_clr) begin
            flag <= 1'b0;
        end else if (set_ev) begin
            flag <= 1'b1;
        end else if (clr_w1) begin
            flag <= 1'b0;
        end
    end
endmodule : scw_flag
`default_nettype wire

// File: verification/scw_status_control_sva.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks on the status and control word
module scw_status_control_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] index_port_rdata,
    input wire logic value_port_wr,
    input wire logic [15:0] value_port_wdata,
    input wire logic descr_fetch_done,
    input wire logic receiver_disable_cfg,
    input wire logic transmitter_disable_cfg,
    input wire logic irq,
    input wire logic stopped,
    input wire logic setup_start,
    input wire logic tx_poll_go,
    input wire logic receiver_active,
    input wire logic transmitter_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // the index read-back lags a cycle, so only settled selections count
    sequence s_stop_wr;
        value_port_wr && index_port_rdata[6:0] == 7'h00 && value_port_wdata[2];
    endsequence
    sequence s_go_wr;
        value_port_wr && index_port_rdata[6:0] == 7'h00 && value_port_wdata[1]
            && !value_port_wdata[2];
    endsequence
    stop_wins_a: assert property (s_stop_wr |=> !setup_start ##1 (stopped && !receiver_active))
        else $error("stop write did not halt");
    go_clears_a: assert property (s_go_wr |-> ##[1:2] !stopped)
        else $error("go write left stop set");
    setup_first_a: assert property (s_go_wr ##0 value_port_wdata[0] |-> ##[1:2] setup_start)
        else $error("setup did not start");
    setup_hold_a: assert property (setup_start |-> !receiver_active && !transmitter_active)
        else $error("active during setup");
    rx_cfg_a: assert property ($rose(receiver_active) |-> !receiver_disable_cfg)
        else $error("receiver on while disabled");
    tx_cfg_a: assert property ($rose(transmitter_active) |-> !transmitter_disable_cfg)
        else $error("transmitter on while disabled");
    poll_gate_a: assert property (tx_poll_go |-> $past(transmitter_active))
        else $error("poll with transmitter off");
    fetch_clear_a: assert property (descr_fetch_done && !value_port_wr |-> ##2 !tx_poll_go)
        else $error("poll kept after fetch");
    stop_irq_a: assert property (stopped |=> !irq)
        else $error("irq while stopped");
endmodule : scw_status_control_sva
bind scw_status_control scw_status_control_sva u_scw_status_control_sva (.clk(clk), .rstn(rstn),
    .index_port_rdata(index_port_rdata), .value_port_wr(value_port_wr),
    .value_port_wdata(value_port_wdata), .descr_fetch_done(descr_fetch_done),
    .receiver_disable_cfg(receiver_disable_cfg),
    .transmitter_disable_cfg(transmitter_disable_cfg), .irq(irq), .stopped(stopped),
    .setup_start(setup_start), .tx_poll_go(tx_poll_go), .receiver_active(receiver_active),
    .transmitter_active(transmitter_active));
`default_nettype wire

// File: verification/scw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the indirect ports; drives only after a falling edge
module scw_host_model (
    input wire logic clk,
    output logic index_port_wr,
    output logic [15:0] index_port_wdata,
    output logic value_port_wr,
    output logic value_port_rd,
    output logic [15:0] value_port_wdata,
    input wire logic [15:0] value_port_rdata
);
    // idle values at time zero
    initial begin
        index_port_wr = 1'b0;
        value_port_wr = 1'b0;
        value_port_rd = 1'b0;
        index_port_wdata = 16'h0000;
        value_port_wdata = 16'h0000;
    end
    // index is always written before the value port is used
    task automatic wr_index(input logic [15:0] v);
        @(negedge clk);
        index_port_wr = 1'b1;
        index_port_wdata = v;
        @(negedge clk);
        index_port_wr = 1'b0;
        index_port_wdata = ~v; // released data must not look valid
    endtask : wr_index
    // poll-now is requested here by the host, auto polling being off
    task automatic wr_value(input logic [15:0] v);
        @(negedge clk);
        value_port_wr = 1'b1;
        value_port_wdata = v;
        @(negedge clk);
        value_port_wr = 1'b0;
        value_port_wdata = ~v;
    endtask : wr_value
    // read word is settled one cycle after the taking edge
    task automatic rd_value(output logic [15:0] v);
        @(negedge clk);
        value_port_rd = 1'b1;
        @(negedge clk);
        value_port_rd = 1'b0;
        @(negedge clk);
        v = value_port_rdata;
    endtask : rd_value
endmodule : scw_host_model
`default_nettype wire

// File: verification/tb_scw_status_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_scw_status_control;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] evs = 8'h00;
    logic [5:0] msk = 6'h00;
    logic [3:0] lvl = 4'h0;
    logic rx_dis = 1'b0;
    logic tx_dis = 1'b0;
    logic iw, vw, vr, irq, stopped, sstart, pgo, ract, tact, p;
    logic [15:0] iwd, vwd, ird, vrd, rv, e;
    int n_errors = 0;
    int n_tests = 0;
    int bitp[6] = '{11, 10, 9, 14, 13, 12};
    logic [5:0] errm = 6'b111001;
    logic [5:0] pendm = 6'b101111;
    always #4 clk = ~clk;
    scw_host_model u_scw_host_model (.clk(clk), .index_port_wr(iw), .index_port_wdata(iwd),
        .value_port_wr(vw), .value_port_rd(vr), .value_port_wdata(vwd), .value_port_rdata(vrd));
    scw_status_control u_scw_status_control (.clk(clk), .rstn(rstn), .index_port_wr(iw),
        .index_port_wdata(iwd), .value_port_wr(vw), .value_port_rd(vr),
        .value_port_wdata(vwd), .index_port_rdata(ird), .value_port_rdata(vrd),
        .bus_timeout_ev(evs[0]), .rx_done_ev(evs[1]), .tx_done_ev(evs[2]),
        .overlong_ev(evs[3]), .colltest_ev(evs[4]), .dropped_ev(evs[5]),
        .setup_read_done(evs[6]), .descr_fetch_done(evs[7]),
        .missed_count_overflow(lvl[0]), .collision_count_overflow(lvl[1]),
        .long_talk_flag(lvl[2]), .tx_begin_flag(lvl[3]), .bus_timeout_mask(msk[0]),
        .rx_done_mask(msk[1]), .tx_done_mask(msk[2]), .overlong_mask(msk[3]),
        .setup_done_mask(msk[4]), .dropped_mask(msk[5]), .receiver_disable_cfg(rx_dis),
        .transmitter_disable_cfg(tx_dis), .auto_poll_disable(1'b1), .irq(irq),
        .stopped(stopped), .setup_start(sstart), .tx_poll_go(pgo),
        .receiver_active(ract), .transmitter_active(tact));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [15:0] exp);
        u_scw_host_model.rd_value(rv);
        chk(rv, exp);
    endtask : rd_chk
    task automatic wr(input logic [15:0] v);
        u_scw_host_model.wr_value(v);
    endtask : wr
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // one-cycle event pulse from an internal unit
    task automatic pulse(input int i);
        @(negedge clk);
        evs[i] = 1'b1;
        @(negedge clk);
        evs[i] = 1'b0;
    endtask : pulse
    task automatic print_verdict();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // a hang must still end in a verdict
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
    // main sequence
    initial begin
        wt(4);
        rstn = 1'b1;
        chk({15'h0, stopped}, 16'h0001);
        u_scw_host_model.wr_index(16'h0001);
        rd_chk(16'h0000); // unmapped index reads zero
        chk(ird, 16'h0001);
        u_scw_host_model.wr_index(16'h0000);
        rd_chk(16'h0004);
        wr(16'h0042);
        wt(4);
        rd_chk(16'h0072);
        chk({14'h0, ract, tact}, 16'h0003);
        // every event flag but setup done, with mask bit i clear then set
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 2; m++) begin
                msk = m[0] ? 6'(1 << i) : 6'h00;
                p = pendm[i] & ~m[0];
                pulse(i);
                e = 16'h0072 | (16'h0001 << bitp[i]) | {errm[i], 15'h0} | {8'h0, p, 7'h0};
                rd_chk(e);
                chk({15'h0, irq}, {15'h0, p});
                wr(16'h0040 | (16'h0001 << bitp[i]));
                rd_chk(16'h0072);
            end
        end
        msk = 6'h00;
        // level sources feed pending directly
        for (int j = 0; j < 4; j++) begin
            lvl = 4'(1 << j);
            wt(2);
            rd_chk(16'h00f2);
            chk({15'h0, irq}, 16'h0001);
            lvl = 4'h0;
            wt(2);
            rd_chk(16'h0072);
        end
        fork
            pulse(1);
            wr(16'h0440);
        join
        rd_chk(16'h04f2);
        wr(16'h0000);
        wt(2);
        rd_chk(16'h04b2);
        chk({15'h0, irq}, 16'h0000);
        wr(16'h0440);
        rd_chk(16'h0072);
        wr(16'h0048);
        wt(2);
        chk({15'h0, pgo}, 16'h0001);
        pulse(7);
        wt(1);
        chk({15'h0, pgo}, 16'h0000);
        rd_chk(16'h0072);
        pulse(2);
        wr(16'h0007);
        wt(1);
        rd_chk(16'h0004);
        chk({13'h0, stopped, sstart, irq}, 16'h0004);
        wr(16'h0008);
        rd_chk(16'h0004);
        rx_dis = 1'b1;
        wr(16'h0003);
        wt(2);
        chk({13'h0, sstart, ract, tact}, 16'h0004);
        pulse(6);
        wt(3);
        rd_chk(16'h0193);
        chk({14'h0, ract, tact}, 16'h0001);
        wr(16'h0040);
        wt(1);
        chk({15'h0, irq}, 16'h0001);
        wr(16'h0140);
        rd_chk(16'h0053);
        // transmitter disabled, receiver enabled
        wr(16'h0004);
        rx_dis = 1'b0;
        tx_dis = 1'b1;
        wt(2);
        wr(16'h0042);
        wt(4);
        rd_chk(16'h0062);
        chk({14'h0, ract, tact}, 16'h0002);
        print_verdict();
    end
endmodule : tb_scw_status_control
`default_nettype wire
